// *** core/hrb_defs.svh ***
/*
 * hrb_defs.svh - constants of the half rate memory bridge.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef HRB_DEFS_SVH
`define HRB_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define HRB_MEM_DW_DEF 16
`define HRB_MEM_AW_DEF 24

// ----------------------------------------------------------------
// burst and timing
// ----------------------------------------------------------------
`define HRB_BURST_LEN 2'h2
`define HRB_BEATS 2
`define HRB_CLK_PERIOD_NS 8

`endif

// *** core/hrb_pkg.sv ***
/*
 * hrb_pkg - types of the half rate memory bridge.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hrb_pkg;

	typedef logic [1:0] hrb_burst_t;

	typedef enum logic [2:0] {
		HRB_IDLE = 3'h0,
		HRB_WR_B0 = 3'h1,
		HRB_WR_B1 = 3'h2,
		HRB_WR_DONE = 3'h3,
		HRB_RD_CMD = 3'h4,
		HRB_RD_WAIT = 3'h5,
		HRB_RD_RET = 3'h6
	} hrb_state_t;

endpackage : hrb_pkg

// *** core/hrb_phase.sv ***
/*
 * hrb_phase - finds the cpu side clock phase within the core clock.
 * Assumes cpu_side_clock is synchronous, half the core rate, zero phase.
 */
`timescale 1ns/100ps
module hrb_phase (
	input wire logic core_clk, // memory side clock
	input wire logic resetn, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic cpu_side_clock, // half rate clock, sampled
	output logic cpu_edge // next core edge is a cpu rising edge
);
	import hrb_pkg::*;

	logic sync1_r, sync2_r;
	logic sync1_nxt, sync2_nxt;

	always_comb begin
		sync1_nxt = sync1_r;
		sync2_nxt = sync2_r;
		if (ce) begin
			sync1_nxt = cpu_side_clock;
			sync2_nxt = sync1_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// two-cycle delay equals the period, so the delayed level is in phase
	assign cpu_edge = ~sync2_r;

endmodule : hrb_phase

// *** core/hrb_join.sv ***
/*
 * hrb_join - gathers two memory side read beats into one cpu word.
 * Assumes beats arrive lower half first.
 */
`timescale 1ns/100ps
`include "hrb_defs.svh"
module hrb_join #(
	parameter int MEM_DW = `HRB_MEM_DW_DEF
) (
	input wire logic core_clk, // memory side clock
	input wire logic resetn, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic clear, // restart the gather
	input wire logic beat_valid, // one read beat present
	input wire logic [MEM_DW-1:0] beat_data, // read beat
	output logic [2*MEM_DW-1:0] word, // joined word
	output logic done // both beats held
);
	import hrb_pkg::*;

	logic [2*MEM_DW-1:0] word_r, word_nxt;
	logic [1:0] cnt_r, cnt_nxt;

	always_comb begin
		word_nxt = word_r;
		cnt_nxt = cnt_r;
		if (ce) begin
			if (clear) begin
				cnt_nxt = 2'h0;
			end else if (beat_valid && cnt_r != `HRB_BURST_LEN) begin
				if (cnt_r == 2'h0) begin
					word_nxt[MEM_DW-1:0] = beat_data;
				end else begin
					word_nxt[2*MEM_DW-1:MEM_DW] = beat_data;
				end
				cnt_nxt = cnt_r + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			word_r <= '0;
			cnt_r <= 2'h0;
		end else begin
			word_r <= word_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign word = word_r;
	assign done = (cnt_r == `HRB_BURST_LEN);

endmodule : hrb_join

// *** core/hrb_bridge.sv ***
/*
 * hrb_bridge - half rate memory bridge: single cpu words become
 * two-beat bursts of half width at twice the rate.
 * Assumes core_clk is the memory side clock and cpu_side_clock is
 * synchronous at half that rate with zero phase; cpu side signals
 * are launched and sampled on cpu rising edges.
 */
`timescale 1ns/100ps
`include "hrb_defs.svh"

// Contract
// RULE_01 - each accepted cpu word request issues exactly one two-beat burst
// RULE_02 - reads wait for both beats, join them, return one word
// RULE_03 - memory side only bursts; cpu side only single words
// RULE_04 - integrator clocks memory side at twice cpu rate, zero phase
// RULE_05 - memory data path is half the cpu data path width
// RULE_06 - reads add one cpu cycle in command, one in response
// RULE_07 - memory data width parameter from 8 to 512, default 16
// RULE_08 - memory address width 1 to 32, default 24, byte address
// RULE_09 - cpu data width is twice memory data width
// RULE_10 - byte enables carry one bit per data byte on each port
// RULE_11 - cpu word address width derived, 22 at defaults
// RULE_12 - integrator matches memory width to controller local width
// RULE_13 - writes go lower half first, cpu stalled until burst accepted
// RULE_14 - further cpu requests stall while a read is outstanding
module hrb_bridge #(
	parameter int MEM_DW = `HRB_MEM_DW_DEF, // RULE_07
	parameter int MEM_AW = `HRB_MEM_AW_DEF, // RULE_08
	parameter int CPU_DW = 2 * MEM_DW, // RULE_09
	parameter int MEM_BEW = MEM_DW / 8, // RULE_10
	parameter int CPU_BEW = CPU_DW / 8, // RULE_10
	parameter int CPU_AW = MEM_AW - $clog2(CPU_BEW) // RULE_11
) (
	input wire logic core_clk, // memory side clock
	input wire logic resetn, // sync reset, active low
	input wire logic ce, // clock enable, freezes state
	input wire logic cpu_side_clock, // half rate cpu clock
	input wire logic [CPU_AW-1:0] cpu_address, // word address
	input wire logic cpu_read, // read request
	input wire logic cpu_write, // write request
	input wire logic [CPU_DW-1:0] cpu_writedata, // write word
	input wire logic [CPU_BEW-1:0] cpu_byteenable, // write lanes
	output logic cpu_waitrequest, // stall
	output logic [CPU_DW-1:0] cpu_readdata, // joined read word
	output logic cpu_readdatavalid, // read word valid
	output logic [MEM_AW-1:0] mem_address, // byte address
	output logic mem_read, // burst read
	output logic mem_write, // write beat
	output logic [MEM_DW-1:0] mem_writedata, // write beat data
	output logic [MEM_BEW-1:0] mem_byteenable, // beat lanes
	output hrb_pkg::hrb_burst_t mem_burstcount, // always two
	input wire logic mem_waitrequest, // controller stall
	input wire logic [MEM_DW-1:0] mem_readdata, // read beat
	input wire logic mem_readdatavalid // read beat valid
);
	import hrb_pkg::*;

	localparam int LSB_W = $clog2(CPU_BEW);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	hrb_state_t state_r, state_nxt;
	logic [CPU_AW-1:0] addr_r, addr_nxt;
	logic [CPU_DW-1:0] wdata_r, wdata_nxt;
	logic [CPU_BEW-1:0] be_r, be_nxt;
	logic [CPU_DW-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic cpu_edge;
	logic join_done;
	logic join_clear;
	logic [CPU_DW-1:0] join_word;
	logic take_rd, take_wr;

	hrb_phase u_phase (
		.core_clk(core_clk),
		.resetn(resetn),
		.ce(ce),
		.cpu_side_clock(cpu_side_clock),
		.cpu_edge(cpu_edge)
	);

	hrb_join #(.MEM_DW(MEM_DW)) u_join (
		.core_clk(core_clk),
		.resetn(resetn),
		.ce(ce),
		.clear(join_clear),
		.beat_valid(mem_readdatavalid),
		.beat_data(mem_readdata),
		.word(join_word),
		.done(join_done)
	);

	assign take_rd = (state_r == HRB_IDLE) && cpu_edge && cpu_read;
	assign take_wr = (state_r == HRB_IDLE) && cpu_edge && cpu_write;
	assign join_clear = take_rd; // RULE_02

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		be_nxt = be_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = rvalid_r;
		if (ce) begin
			// hold valid for exactly one cpu cycle
			if (cpu_edge) begin
				rvalid_nxt = 1'b0;
			end
			case (state_r)
			HRB_IDLE: begin
				if (take_rd) begin
					addr_nxt = cpu_address;
					state_nxt = HRB_RD_CMD; // RULE_06
				end else if (take_wr) begin
					addr_nxt = cpu_address;
					wdata_nxt = cpu_writedata;
					be_nxt = cpu_byteenable;
					state_nxt = HRB_WR_B0; // RULE_01
				end
			end
			HRB_WR_B0: begin
				if (!mem_waitrequest) begin
					state_nxt = HRB_WR_B1; // RULE_13
				end
			end
			HRB_WR_B1: begin
				if (!mem_waitrequest) begin
					state_nxt = HRB_WR_DONE; // RULE_13
				end
			end
			HRB_WR_DONE: begin
				if (cpu_edge) begin
					state_nxt = HRB_IDLE;
				end
			end
			HRB_RD_CMD: begin
				if (!mem_waitrequest) begin
					state_nxt = HRB_RD_WAIT;
				end
			end
			HRB_RD_WAIT: begin
				if (join_done) begin
					state_nxt = HRB_RD_RET; // RULE_02
				end
			end
			HRB_RD_RET: begin
				// second latency cycle: returned on the next cpu edge
				if (cpu_edge) begin
					rdata_nxt = join_word; // RULE_02
					rvalid_nxt = 1'b1; // RULE_06
					state_nxt = HRB_IDLE;
				end
			end
			default: begin
				state_nxt = HRB_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= HRB_IDLE;
			addr_r <= '0;
			wdata_r <= '0;
			be_r <= '0;
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			be_r <= be_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ------------------------------------------------------------
	// port drive
	// ------------------------------------------------------------
	// writes stall until their burst is taken; reads are taken at once
	always_comb begin
		case (state_r)
		HRB_IDLE: cpu_waitrequest = cpu_write; // RULE_13
		HRB_WR_DONE: cpu_waitrequest = 1'b0;
		default: cpu_waitrequest = 1'b1; // RULE_14
		endcase
	end

	assign cpu_readdata = rdata_r;
	assign cpu_readdatavalid = rvalid_r;
	assign mem_address = {addr_r, {LSB_W{1'b0}}}; // RULE_08
	assign mem_read = (state_r == HRB_RD_CMD); // RULE_01
	assign mem_write = (state_r == HRB_WR_B0) || (state_r == HRB_WR_B1);
	assign mem_burstcount = `HRB_BURST_LEN; // RULE_03
	// half width beats, lower half first
	assign mem_writedata = (state_r == HRB_WR_B1) ?
		wdata_r[CPU_DW-1:MEM_DW] : wdata_r[MEM_DW-1:0]; // RULE_05
	assign mem_byteenable = (state_r == HRB_WR_B1) ?
		be_r[CPU_BEW-1:MEM_BEW] : be_r[MEM_BEW-1:0]; // RULE_13

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	localparam int RET_MIN = 2;
	localparam int RET_MAX = 3;

	burst_len_a: assert property (@(posedge core_clk) // RULE_03
		disable iff (!resetn)
		(mem_read || mem_write) |-> mem_burstcount == `HRB_BURST_LEN)
		else $error("burst count is not two");

	wr_issue_a: assert property (@(posedge core_clk) // RULE_01
		disable iff (!resetn || !ce)
		(take_wr && ce) |=> mem_write && !mem_read &&
			mem_address == {$past(cpu_address), {LSB_W{1'b0}}})
		else $error("write burst not issued after capture");

	rd_issue_a: assert property (@(posedge core_clk) // RULE_06
		disable iff (!resetn || !ce)
		(take_rd && ce) |=> mem_read && !mem_write)
		else $error("read burst not issued one cycle after capture");

	wr_lower_a: assert property (@(posedge core_clk) // RULE_13
		disable iff (!resetn)
		(state_r == HRB_WR_B0) |-> mem_writedata == wdata_r[MEM_DW-1:0] &&
			mem_byteenable == be_r[MEM_BEW-1:0])
		else $error("first write beat is not the lower half");

	wr_upper_a: assert property (@(posedge core_clk) // RULE_13
		disable iff (!resetn || !ce)
		(state_r == HRB_WR_B0 && !mem_waitrequest && ce) |=>
			mem_write && mem_writedata == wdata_r[CPU_DW-1:MEM_DW])
		else $error("second write beat is not the upper half");

	wr_stall_a: assert property (@(posedge core_clk) // RULE_13
		disable iff (!resetn)
		(mem_write || (state_r == HRB_IDLE && cpu_write)) |->
			cpu_waitrequest)
		else $error("cpu write released before burst taken");

	rd_stall_a: assert property (@(posedge core_clk) // RULE_14
		disable iff (!resetn)
		(mem_read || state_r == HRB_RD_WAIT || state_r == HRB_RD_RET)
			|-> cpu_waitrequest && !mem_write)
		else $error("cpu request let through during read");

	rd_return_a: assert property (@(posedge core_clk) // RULE_06
		disable iff (!resetn || !ce)
		(state_r == HRB_RD_WAIT && join_done && ce) |->
			##[RET_MIN:RET_MAX] $rose(cpu_readdatavalid))
		else $error("joined read word not returned in time");

	rd_join_a: assert property (@(posedge core_clk) // RULE_02
		disable iff (!resetn)
		$rose(cpu_readdatavalid) |-> cpu_readdata == $past(join_word) &&
			$past(join_done))
		else $error("read word is not the two joined beats");

	rd_width_a: assert property (@(posedge core_clk) // RULE_02
		disable iff (!resetn || !ce)
		$rose(cpu_readdatavalid) |=> cpu_readdatavalid ##1
			!cpu_readdatavalid)
		else $error("read valid not one cpu cycle wide");

	rd_addr_a: assert property (@(posedge core_clk) // RULE_08
		disable iff (!resetn || !ce)
		(take_rd && ce) |=> mem_read &&
			mem_address == {$past(cpu_address), {LSB_W{1'b0}}})
		else $error("read burst address is not the cpu byte address");

	wr_done_a: assert property (@(posedge core_clk) // RULE_13
		disable iff (!resetn || !ce)
		(state_r == HRB_WR_B1 && !mem_waitrequest && ce) |=>
			!cpu_waitrequest && !mem_write)
		else $error("cpu write not released after burst taken");

	freeze_hold_a: assert property (@(posedge core_clk) // RULE_01
		disable iff (!resetn)
		!ce |=> $stable(state_r) && $stable(cpu_readdatavalid))
		else $error("state moved while clock enable low");

	cov_write_c: cover property (@(posedge core_clk)
		disable iff (!resetn)
		state_r == HRB_WR_B1 ##1 state_r == HRB_WR_DONE);

	cov_read_c: cover property (@(posedge core_clk)
		disable iff (!resetn)
		$rose(cpu_readdatavalid));

	cov_stall_c: cover property (@(posedge core_clk)
		disable iff (!resetn)
		mem_read && mem_waitrequest);

	cov_b2b_c: cover property (@(posedge core_clk)
		disable iff (!resetn)
		cpu_readdatavalid && take_rd);

endmodule : hrb_bridge

// *** dv/hrb_mem_model.sv ***
/*
 * hrb_mem_model - behavioural memory controller for the bridge bench.
 * Assumes default widths and one open burst at a time on core_clk.
 */
`timescale 1ns/100ps
module hrb_mem_model (
	input wire logic core_clk, // memory clock
	input wire logic resetn, // sync reset, active low
	input wire logic [31:0] stall, // wait cycles per request
	input wire logic [23:0] mem_address, // byte address
	input wire logic mem_read, // burst read
	input wire logic mem_write, // write beat
	input wire logic [15:0] mem_writedata, // beat data
	input wire logic [1:0] mem_byteenable, // beat lanes
	input wire logic [1:0] mem_burstcount, // beats per burst
	output logic mem_waitrequest, // stall
	output logic [15:0] mem_readdata, // read beat
	output logic mem_readdatavalid // beat valid
);
	int cnt, bursts, left, widx;
	logic [15:0] rd_w, wd0, wd1;
	logic [1:0] wb0, wb1, bc;
	logic [23:0] wa;
	assign mem_waitrequest = (mem_read | mem_write) && cnt < stall;
	always @(posedge core_clk) begin
		if (!resetn) begin
			cnt <= 0;
			bursts <= 0;
			left <= 0;
			widx <= 0;
			mem_readdatavalid <= 1'b0;
		end else begin
			cnt <= mem_waitrequest ? cnt + 1 : 0;
			// idle data toggles so a stale beat cannot pass
			mem_readdatavalid <= left > 0;
			mem_readdata <= left == 2 ? rd_w : ~mem_readdata;
			if (left > 0)
				left <= left - 1;
			if (mem_read && !mem_waitrequest) begin
				bursts <= bursts + 1;
				bc <= mem_burstcount;
				rd_w <= mem_address[17:2];
				left <= 2;
			end
			if (mem_write && !mem_waitrequest) begin
				widx <= 1 - widx;
				if (widx == 0) begin
					bursts <= bursts + 1;
					bc <= mem_burstcount;
					wa <= mem_address;
					wd0 <= mem_writedata;
					wb0 <= mem_byteenable;
				end else begin
					wd1 <= mem_writedata;
					wb1 <= mem_byteenable;
				end
			end
		end
	end
endmodule : hrb_mem_model

// *** dv/hrb_bridge_tb.sv ***
/*
 * hrb_bridge_tb - self-checking bench of the half rate bridge.
 * Assumes default widths; cpu clock made here at half core rate.
 */
`timescale 1ns/100ps
module hrb_bridge_tb;
	import hrb_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic cpu_side_clock = 1'b0;
	logic [21:0] cpu_address = '0;
	logic cpu_read = 1'b0;
	logic cpu_write = 1'b0;
	logic [31:0] cpu_writedata = '0;
	logic [3:0] cpu_byteenable = '0;
	logic cpu_waitrequest, cpu_readdatavalid, mem_read, mem_write;
	logic mem_waitrequest, mem_readdatavalid;
	logic [31:0] cpu_readdata;
	logic [23:0] mem_address;
	logic [15:0] mem_writedata, mem_readdata;
	logic [1:0] mem_byteenable;
	hrb_burst_t mem_burstcount;
	int stall = 0;
	int num_errors = 0;
	int comparisons = 0;

	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) cpu_side_clock <= ~cpu_side_clock;

	hrb_bridge u_hrb_bridge (.core_clk(core_clk), .resetn(resetn), .ce(ce),
		.cpu_side_clock(cpu_side_clock), .cpu_address(cpu_address),
		.cpu_read(cpu_read), .cpu_write(cpu_write),
		.cpu_writedata(cpu_writedata), .cpu_byteenable(cpu_byteenable),
		.cpu_waitrequest(cpu_waitrequest), .cpu_readdata(cpu_readdata),
		.cpu_readdatavalid(cpu_readdatavalid), .mem_address(mem_address),
		.mem_read(mem_read), .mem_write(mem_write),
		.mem_writedata(mem_writedata), .mem_byteenable(mem_byteenable),
		.mem_burstcount(mem_burstcount), .mem_waitrequest(mem_waitrequest),
		.mem_readdata(mem_readdata), .mem_readdatavalid(mem_readdatavalid));
	hrb_mem_model u_hrb_mem_model (.core_clk(core_clk), .resetn(resetn),
		.stall(stall), .mem_address(mem_address), .mem_read(mem_read),
		.mem_write(mem_write), .mem_writedata(mem_writedata),
		.mem_byteenable(mem_byteenable), .mem_burstcount(mem_burstcount),
		.mem_waitrequest(mem_waitrequest), .mem_readdata(mem_readdata),
		.mem_readdatavalid(mem_readdatavalid));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tmo(input int n, lim);
		if (n >= lim) begin
			num_errors++;
			end_of_test();
		end
	endtask : tmo

	// returns just after a core edge that is a cpu rising edge
	task automatic cpu_edge_w();
		int i;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (cpu_side_clock !== 1'b0 && i < 4);
		if (cpu_side_clock !== 1'b0)
			tmo(1, 1);
	endtask : cpu_edge_w

	task automatic do_read(input logic [21:0] a, input int exp_n);
		int n;
		int b0;
		b0 = u_hrb_mem_model.bursts;
		cpu_address <= a;
		cpu_read <= 1'b1;
		n = 0;
		do begin
			cpu_edge_w();
			n++;
		end while (cpu_waitrequest !== 1'b0 && n < 20);
		tmo(n, 20);
		cpu_read <= 1'b0;
		n = 0;
		do begin
			cpu_edge_w();
			n++;
			if (n == 1)
				chk("rd stall", cpu_waitrequest, 1'b1);
		end while (cpu_readdatavalid !== 1'b1 && n < 30);
		tmo(n, 30);
		chk("rd lat", n, exp_n);
		chk("rdata", cpu_readdata, {~a[15:0], a[15:0]});
		chk("rd bursts", u_hrb_mem_model.bursts - b0, 1);
		chk("rd count", u_hrb_mem_model.bc, 2'h2);
	endtask : do_read

	task automatic do_write(input logic [21:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		int b0;
		b0 = u_hrb_mem_model.bursts;
		cpu_address <= a;
		cpu_writedata <= d;
		cpu_byteenable <= be;
		cpu_write <= 1'b1;
		n = 0;
		do begin
			cpu_edge_w();
			n++;
		end while (cpu_waitrequest !== 1'b0 && n < 30);
		tmo(n, 30);
		cpu_write <= 1'b0;
		// one idle cpu cycle keeps back-to-back writes from colliding
		cpu_edge_w();
		chk("wr idle", cpu_waitrequest, 1'b0);
		chk("wr addr", u_hrb_mem_model.wa, {a, 2'h0});
		chk("wr d0", u_hrb_mem_model.wd0, d[15:0]);
		chk("wr d1", u_hrb_mem_model.wd1, d[31:16]);
		chk("wr be0", u_hrb_mem_model.wb0, be[1:0]);
		chk("wr be1", u_hrb_mem_model.wb1, be[3:2]);
		chk("wr bursts", u_hrb_mem_model.bursts - b0, 1);
		chk("wr count", u_hrb_mem_model.bc, 2'h2);
	endtask : do_write

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_params();
		chk("mem dw", $bits(mem_writedata), 16);
		chk("cpu dw", $bits(cpu_writedata), 32);
		chk("mem be", $bits(mem_byteenable), 2);
		chk("cpu be", $bits(cpu_byteenable), 4);
		chk("mem aw", $bits(mem_address), 24);
		chk("cpu aw", $bits(cpu_address), 22);
		chk("half", 2 * $bits(mem_readdata), $bits(cpu_readdata));
	endtask : t_params

	task automatic t_reset();
		chk("rst valid", cpu_readdatavalid, 1'b0);
		chk("rst rd", mem_read, 1'b0);
		chk("rst wr", mem_write, 1'b0);
		chk("rst count", mem_burstcount, 2'h2);
	endtask : t_reset

	task automatic t_writes();
		stall = 0;
		do_write(22'h3fffff, 32'h1234abcd, 4'h9);
		stall = 3;
		do_write(22'h000001, 32'hfedc0123, 4'h6);
	endtask : t_writes

	task automatic t_reads();
		stall = 0;
		do_read(22'h00a5c3, 4);
		do_read(22'h3f0f0f, 4);
		// each stalled core cycle pair adds one cpu cycle
		stall = 4;
		do_read(22'h12ffff, 6);
	endtask : t_reads

	// a request held while frozen must not start a burst; even length
	// keeps the phase finder aligned when the enable returns
	task automatic t_freeze();
		stall = 0;
		ce <= 1'b0;
		cpu_address <= 22'h001234;
		cpu_read <= 1'b1;
		repeat (4) begin
			@(posedge core_clk);
			chk("frz rd", mem_read, 1'b0);
			chk("frz valid", cpu_readdatavalid, 1'b0);
		end
		ce <= 1'b1;
		do_read(22'h001234, 4);
	endtask : t_freeze

	initial begin
		repeat (2) @(posedge core_clk);
		// outputs are looked at once the first reset edge has set them
		t_reset();
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		cpu_edge_w();
		t_params();
		t_writes();
		t_reads();
		t_freeze();
		end_of_test();
	end
endmodule : hrb_bridge_tb
